//--- rtl/tlc_top.sv
/*
  Low and high threshold registers with end-of-conversion compare.
  Assumes the serial front end gives one-cycle write and read strobes
  with a 2-bit pointer, and the converter a one-cycle done pulse.
*/
// Notes on behaviour
// - low threshold at pointer 10, reset F600h.
// - high threshold at pointer 11, reset 3C00h.
// - reset encodings mean -10/+60 degrees only in 12-bit format.
// - on conversion done, result below low threshold sets below flag.
// - on conversion done, result above high threshold sets above flag.
// - in 12-bit mode writes to bit 3 of thresholds are ignored.
// - 12-bit low layout: value 15:4, bit 3, bits 2:0 read zero.
// - 13-bit low layout: value 15:3, bits 2:0 read zero.
// - 12-bit high layout: value 15:4, bit 3, bits 2:0 read zero.
// - 13-bit high layout: value 15:3, bits 2:0 read zero.
// - temperatures and thresholds are signed two's complement.
// - one LSB weighs 0.0625 degrees in both formats.
// - latch select 0 clears flags on read; 1 keeps them latched.
`timescale 1ns/100ps
`default_nettype none
module tlc_top
  import tlc_pkg::*;
(
  input  wire logic        clk,                   // 40 MHz clock
  input  wire logic        nrst,                  // Async reset, low
  input  wire logic        extended_range_select, // 13-bit format
  input  wire logic        flag_latch_select,     // Keep flags latched
  input  wire logic [1:0]  reg_ptr,               // Register pointer
  input  wire logic        reg_wr,                // Write strobe
  input  wire logic        reg_rd,                // Read strobe
  input  wire logic [15:0] reg_wdata,             // Write data
  output logic [15:0]      reg_rdata,             // Read data
  input  wire logic        conv_done,             // Conversion done
  input  wire logic [15:0] conv_result,           // Result word
  input  wire logic        cfg_rd,                // Config reg read
  output logic             below_threshold_flag,  // Low limit crossed
  output logic             above_threshold_flag   // High limit crossed
);
  typedef struct packed {
    logic [15:0] low;
    logic [15:0] high;
    logic [15:0] rdata;
    logic        below;
    logic        above;
  } tlc_state_t;

  tlc_state_t st_reg;
  tlc_state_t st_next;
  logic [15:0] mask;
  logic [15:0] wmask;
  logic        cmp_below;
  logic        cmp_above;

  // Format mask: bit 3 is value in 13-bit mode, a stored flag otherwise.
  // One LSB weighs the same in both formats, so no rescale is needed
  // before the compare; only the unused low bits are cut off.
  assign mask  = extended_range_select ? TLC_MASK_EXT
                                       : TLC_MASK_STD;
  // Bit 3 writable only in 13-bit mode; stays put otherwise
  assign wmask = extended_range_select ? TLC_MASK_EXT : TLC_MASK_STD;

  // Write merge: bits 2:0 are dropped, bit 3 keeps its old value unless
  // the format makes it part of the value
  function automatic logic [15:0] merge_word
  (
    logic [15:0] old_word,
    logic [15:0] new_word,
    logic [15:0] wr_mask
  );
    merge_word = (new_word & wr_mask) | (old_word & ~wr_mask & TLC_EXT_MASK);
  endfunction : merge_word

  // Read view of a threshold: reserved bits 2:0 always read as zero
  function automatic logic [15:0] read_word
  (
    logic [15:0] word
  );
    read_word = word & TLC_MASK_EXT;
  endfunction : read_word

  // The field layout only fits a 16-bit register word
  if (TLC_DATA_W != 16)
  begin : g_word_check
    $error("threshold word must be 16 bits");
  end

  tlc_cmp u_cmp
  (
    .result (conv_result),
    .limit  (st_reg.low),
    .mask   (mask),
    .below  (cmp_below),
    .above  ()
  );

  tlc_cmp u_cmp_hi
  (
    .result (conv_result),
    .limit  (st_reg.high),
    .mask   (mask),
    .below  (),
    .above  (cmp_above)
  );

  // Next state: writes, read data, flags with set winning over clear
  always_comb
  begin
    st_next = st_reg;
    if (reg_wr && reg_ptr == TLC_PTR_LOW)
      st_next.low = merge_word(st_reg.low, reg_wdata, wmask);
    if (reg_wr && reg_ptr == TLC_PTR_HIGH)
      st_next.high = merge_word(st_reg.high, reg_wdata, wmask);
    if (reg_rd)
    begin
      unique case (reg_ptr)
        TLC_PTR_LOW:  st_next.rdata = read_word(st_reg.low);
        TLC_PTR_HIGH: st_next.rdata = read_word(st_reg.high);
        default:      st_next.rdata = 16'h0000;
      endcase
    end
    if (cfg_rd && !flag_latch_select)
    begin
      st_next.below = 1'h0;
      st_next.above = 1'h0;
    end
    if (conv_done && cmp_below)
      st_next.below = 1'h1;
    if (conv_done && cmp_above)
      st_next.above = 1'h1;
  end

  // State register; reset values hold only the 12-bit meaning
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg.low   <= TLC_LOW_RST;
      st_reg.high  <= TLC_HIGH_RST;
      st_reg.rdata <= 16'h0000;
      st_reg.below <= 1'h0;
      st_reg.above <= 1'h0;
    end
    else
      st_reg <= st_next;
  end

  assign reg_rdata            = st_reg.rdata;
  assign below_threshold_flag = st_reg.below;
  assign above_threshold_flag = st_reg.above;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Set paths: a conversion that crosses a limit must raise its flag
  a_low_set_flag: assert property (
    conv_done && cmp_below |=> st_reg.below)
    else $error("below flag not set");
  a_high_set_flag: assert property (
    conv_done && cmp_above |=> st_reg.above)
    else $error("above flag not set");
  // No flag may rise without a conversion that crossed its limit
  a_below_no_cause: assert property (
    !st_reg.below && !(conv_done && cmp_below) |=> !st_reg.below)
    else $error("below flag set without cause");
  a_above_no_cause: assert property (
    !st_reg.above && !(conv_done && cmp_above) |=> !st_reg.above)
    else $error("above flag set without cause");
  // Bit 3 is frozen in 12-bit mode for both thresholds
  a_ext_bit_hold: assert property (
    reg_wr && reg_ptr == TLC_PTR_LOW && !extended_range_select
    |=> st_reg.low[TLC_EXT_BIT] == $past(st_reg.low[TLC_EXT_BIT]))
    else $error("bit 3 written in 12-bit mode");
  a_hi_ext_hold: assert property (
    reg_wr && reg_ptr == TLC_PTR_HIGH && !extended_range_select
    |=> st_reg.high[TLC_EXT_BIT] == $past(st_reg.high[TLC_EXT_BIT]))
    else $error("high bit 3 written in 12-bit mode");
  // Value fields take the written word in either format
  a_low_write_val: assert property (
    reg_wr && reg_ptr == TLC_PTR_LOW
    |=> st_reg.low[15:4] == $past(reg_wdata[15:4]))
    else $error("low threshold not written");
  a_high_write_val: assert property (
    reg_wr && reg_ptr == TLC_PTR_HIGH
    |=> st_reg.high[15:4] == $past(reg_wdata[15:4]))
    else $error("high threshold not written");
  a_low_ext_write: assert property (
    reg_wr && reg_ptr == TLC_PTR_LOW && extended_range_select
    |=> st_reg.low[15:3] == $past(reg_wdata[15:3]))
    else $error("low 13-bit value not written");
  a_high_ext_write: assert property (
    reg_wr && reg_ptr == TLC_PTR_HIGH && extended_range_select
    |=> st_reg.high[15:3] == $past(reg_wdata[15:3]))
    else $error("high 13-bit value not written");
  // Writes to pointers owned elsewhere leave both thresholds alone
  a_unmapped_ignore: assert property (
    reg_wr && reg_ptr != TLC_PTR_LOW && reg_ptr != TLC_PTR_HIGH
    |=> $stable(st_reg.low) && $stable(st_reg.high))
    else $error("unmapped write changed a threshold");
  // Reserved bits are never stored and always read as zero
  a_rsvd_read_zero: assert property (reg_rdata[2:0] == 3'h0)
    else $error("reserved bits nonzero");
  a_rsvd_store_zero: assert property (
    st_reg.low[2:0] == 3'h0 && st_reg.high[2:0] == 3'h0)
    else $error("reserved bits stored");
  // A read returns the threshold as it stood before the read edge
  a_read_low_val: assert property (
    reg_rd && reg_ptr == TLC_PTR_LOW |=> reg_rdata == $past(st_reg.low))
    else $error("low threshold read wrong");
  a_read_high_val: assert property (
    reg_rd && reg_ptr == TLC_PTR_HIGH |=> reg_rdata == $past(st_reg.high))
    else $error("high threshold read wrong");
  // Clear on read only when latching is off; a same-cycle set wins
  a_flag_clear_read: assert property (
    cfg_rd && !flag_latch_select && !conv_done
    |=> !st_reg.below && !st_reg.above)
    else $error("flags not cleared on read");
  a_flag_latched: assert property (
    st_reg.above && flag_latch_select |=> st_reg.above)
    else $error("latched flag lost");
  a_below_latched: assert property (
    st_reg.below && flag_latch_select |=> st_reg.below)
    else $error("latched below flag lost");

  c_below_hit: cover property (conv_done && cmp_below);
  c_above_hit: cover property (conv_done && cmp_above);
  c_ext_write: cover property (reg_wr && extended_range_select);
  c_flag_cleared: cover property (
    cfg_rd && !flag_latch_select && st_reg.below);
  c_flag_kept: cover property (
    cfg_rd && flag_latch_select && st_reg.above);
endmodule : tlc_top
`default_nettype wire

//--- rtl/tlc_pkg.sv
/*
  Constants shared by the threshold compare block: register pointers,
  field positions and reset values of the two threshold registers.
  Assumes a register port driven by a serial front end on clk.
*/
`default_nettype none
package tlc_pkg;
  localparam int unsigned  TLC_DATA_W     = 16;
  localparam logic [1:0]   TLC_PTR_LOW    = 2'h2;
  localparam logic [1:0]   TLC_PTR_HIGH   = 2'h3;
  localparam logic [15:0]  TLC_LOW_RST    = 16'hF600;
  localparam logic [15:0]  TLC_HIGH_RST   = 16'h3C00;
  localparam int unsigned  TLC_EXT_BIT    = 3;
  localparam logic [15:0]  TLC_MASK_STD   = 16'hFFF0;
  localparam logic [15:0]  TLC_MASK_EXT   = 16'hFFF8;
  localparam logic [15:0]  TLC_EXT_MASK   = 16'h0008;
  localparam real          TLC_LSB_DEGC   = 0.0625;
endpackage : tlc_pkg
`default_nettype wire

//--- rtl/tlc_cmp.sv
/*
  Signed compare of a conversion result against one threshold.
  Assumes both words share the alignment chosen by the range select.
*/
`timescale 1ns/100ps
`default_nettype none
module tlc_cmp
(
  input  wire logic [15:0] result,    // Conversion result word
  input  wire logic [15:0] limit,     // Threshold word
  input  wire logic [15:0] mask,      // Valid value bits for the format
  output logic             below,     // Result strictly below limit
  output logic             above      // Result strictly above limit
);
  logic signed [15:0] r_s;
  logic signed [15:0] l_s;
  // Masking both sides keeps the flag bit out of the compare
  assign r_s   = $signed(result & mask);
  assign l_s   = $signed(limit & mask);
  assign below = r_s < l_s;
  assign above = r_s > l_s;
endmodule : tlc_cmp
`default_nettype wire

//--- verif/tlc_host_model.sv
/*
  Host side of the register port: one-cycle strobes of whole words.
  Assumes one clock and a read answer registered one edge later.
*/
`timescale 1ns/100ps
`default_nettype none
module tlc_host_model
(
  input  wire logic        clk,       // Bench clock
  output logic [1:0]       reg_ptr,   // Register pointer
  output logic             reg_wr,    // Write strobe
  output logic             reg_rd,    // Read strobe
  output logic [15:0]      reg_wdata, // Write word
  output logic             cfg_rd     // Config read strobe
);
  initial {reg_ptr, reg_wr, reg_rd, cfg_rd, reg_wdata} = '0;
  // Released data shows the inverse so stale words never look valid
  task automatic pulse(logic [1:0] p, logic w, logic r, logic c,
                       logic [15:0] d);
    @(posedge clk);
    #1 {reg_ptr, reg_wr, reg_rd, cfg_rd, reg_wdata} = {p, w, r, c, d};
    @(posedge clk);
    #1 {reg_wr, reg_rd, cfg_rd, reg_wdata} = {3'h0, ~d};
  endtask : pulse
endmodule : tlc_host_model
`default_nettype wire

//--- verif/tlc_top_bench.sv
/*
  Self-checking bench of the threshold block; host model drives the
  register port, the bench plays the converter. Single 40 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
  num_errors++; $display("Error %s exp %h got %h", n, e, s); end end
module tlc_top_bench;
  import tlc_pkg::*;
  logic        clk = 0, nrst = 0, ext = 0, lat = 0, done = 0;
  logic [15:0] res = '0, rdata, wd;
  logic [1:0]  ptr;
  logic        wr, rd, crd, bf, af;
  int          num_errors = 0, n_checks = 0;
  always #12.5 clk = ~clk;
  tlc_host_model host_u (.clk(clk), .reg_ptr(ptr), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wd), .cfg_rd(crd));
  tlc_top dut_u (.clk(clk), .nrst(nrst), .extended_range_select(ext),
    .flag_latch_select(lat), .reg_ptr(ptr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wd), .reg_rdata(rdata), .conv_done(done),
    .conv_result(res), .cfg_rd(crd), .below_threshold_flag(bf),
    .above_threshold_flag(af));
  task automatic wr_rd(string n, logic [1:0] p, logic [15:0] d, e);
    host_u.pulse(p, 1'h1, 1'h0, 1'h0, d);
    host_u.pulse(p, 1'h0, 1'h1, 1'h0, 16'h0000);
    `CHK(n, e, rdata)
  endtask : wr_rd
  // Converter pulse; flags checked just after the edge that takes it
  task automatic conv(logic [15:0] r, logic eb, ea);
    @(posedge clk);
    #1 {done, res} = {1'h1, r};
    @(posedge clk);
    #1 {done, res} = {1'h0, ~r};
    `CHK("below", eb, bf)
    `CHK("above", ea, af)
  endtask : conv
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (2) @(posedge clk);
    #1 nrst = 1'h1;
    host_u.pulse(TLC_PTR_LOW, 1'h0, 1'h1, 1'h0, 16'h0000);
    `CHK("low_rst", TLC_LOW_RST, rdata)
    host_u.pulse(TLC_PTR_HIGH, 1'h0, 1'h1, 1'h0, 16'h0000);
    `CHK("high_rst", TLC_HIGH_RST, rdata)
    wr_rd("unmapped", 2'h0, 16'h5555, 16'h0000);
    wr_rd("low12", TLC_PTR_LOW, 16'h123F, 16'h1230);
    wr_rd("high12", TLC_PTR_HIGH, 16'h7FFF, 16'h7FF0);
    ext = 1'h1;
    wr_rd("low13", TLC_PTR_LOW, 16'hFFFF, 16'hFFF8);
    wr_rd("high13", TLC_PTR_HIGH, 16'h0017, 16'h0010);
    conv(16'hFFF0, 1'h1, 1'h0);
    host_u.pulse(2'h1, 1'h0, 1'h0, 1'h1, 16'h0000);
    conv(16'h0010, 1'h0, 1'h0);
    conv(16'h0018, 1'h0, 1'h1);
    lat = 1'h1;
    host_u.pulse(2'h1, 1'h0, 1'h0, 1'h1, 16'h0000);
    conv(16'h0010, 1'h0, 1'h1);
    {ext, lat} = 2'h0;
    // Bit 3 still holds the 13-bit write; 12-bit writes cannot clear it
    wr_rd("low_back", TLC_PTR_LOW, 16'h0100, 16'h0108);
    wr_rd("high_back", TLC_PTR_HIGH, 16'h0200, 16'h0200);
    host_u.pulse(2'h1, 1'h0, 1'h0, 1'h1, 16'h0000);
    conv(16'h0208, 1'h0, 1'h0);
    conv(16'h00F8, 1'h1, 1'h0);
    final_report();
  end
  // Whole run is under 200 cycles; cut a hang well past that
  initial
  begin
    #20000;
    num_errors++;
    final_report();
  end
endmodule : tlc_top_bench
`default_nettype wire
